// file: pkg/tc_pkg.sv
// Register map, field layout and bus carriers for the timer block
package tc_pkg;

  // Per-channel register offsets within one channel group
  localparam logic [5:0] CH_CMD = 6'h00;
  localparam logic [5:0] CH_MODE = 6'h04;
  localparam logic [5:0] CH_STEP = 6'h08;
  localparam logic [5:0] CH_CV = 6'h10;
  localparam logic [5:0] CH_RA = 6'h14;
  localparam logic [5:0] CH_RB = 6'h18;
  localparam logic [5:0] CH_RC = 6'h1C;
  localparam logic [5:0] CH_SR = 6'h20;
  localparam logic [5:0] CH_IER = 6'h24;
  localparam logic [5:0] CH_IDR = 6'h28;
  localparam logic [5:0] CH_IMR = 6'h2C;
  localparam logic [7:0] CH_STRIDE = 8'h40;
  localparam logic [7:0] CH_AREA_END = 8'hC0;
  localparam int NUM_CH = 3;

  // Block-wide register offsets
  localparam logic [7:0] BLK_CMD = 8'hC0;
  localparam logic [7:0] BLK_MODE = 8'hC4;
  localparam logic [7:0] Q_IER = 8'hC8;
  localparam logic [7:0] Q_IDR = 8'hCC;
  localparam logic [7:0] Q_IMR = 8'hD0;
  localparam logic [7:0] Q_ISR = 8'hD4;
  localparam logic [7:0] FAULT_CFG = 8'hD8;
  localparam logic [7:0] LOCK_CFG = 8'hE4;

  // Channel command, mode and status fields, and block sync command bit
  localparam int CMD_CLK_ON = 0;
  localparam int CMD_CLK_OFF = 1;
  localparam int CMD_TRIG = 2;
  localparam int MODE_WAVE = 15;
  localparam int SR_CLK_STA = 16;
  localparam int BLK_SYNC = 0;

  // Block mode fields
  localparam int BM_L0 = 0;
  localparam int BM_L1 = 2;
  localparam int BM_L2 = 4;
  localparam int BM_DEC_ON = 8;
  localparam int BM_POS = 9;
  localparam int BM_SPEED = 10;
  localparam int BM_BYPASS = 11;
  localparam int BM_SINGLE = 12;
  localparam int BM_INVERT_QUAD_A = 13;
  localparam int BM_INVERT_QUAD_B = 14;
  localparam int BM_INVERT_INDEX = 15;
  localparam int BM_SWAP = 16;
  localparam int BM_IDXB = 17;
  localparam int BM_FILTER = 19;
  localparam int BM_FLEN = 20;
  localparam int FLEN_W = 6;
  localparam logic [31:0] BMR_MASK = 32'h03FB_FF3F;

  // External clock line source codes
  localparam logic [1:0] SEL_PIN = 2'h0;
  localparam logic [1:0] SEL_X = 2'h2;
  localparam logic [1:0] SEL_Y = 2'h3;

  // Decoder status bits and write lock passcode
  localparam int QS_IDX = 0;
  localparam int QS_FLIP = 1;
  localparam int QS_FAULT = 2;
  localparam int QS_DIR = 8;
  localparam logic [23:0] LOCK_KEY = 24'h54_494D;
  localparam int LOCK_KEY_LSB = 8;

  // Synchronised pin indices and gap counter limit
  localparam int P_CLK0 = 0;
  localparam int P_A0 = 3;
  localparam int P_B0 = 4;
  localparam int P_A1 = 5;
  localparam int P_A2 = 6;
  localparam logic [6:0] GAP_MAX = 7'h7F;

  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic hready;
  } ahb_in_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_out_s;

endpackage

// file: logic/timer_block.sv
// Timer block register layer with quadrature decoder front end
//
// Overview of operation
// R1 - Three channels, groups spaced 0x40 apart
// R2 - RA and RB read-only in capture mode
// R3 - Block sync bit triggers all channels together
// R4 - Block mode writes ignored while locked
// R5 - Line 0 source: pin, chan1 A, chan2 A
// R6 - Line 1 source: pin, chan0 A, chan2 A
// R7 - Line 2 source: pin, chan1 A, chan2 A
// R8 - Software pairs decoder enable with a measure mode
// R9 - Position mode counts on channels 0 and 1
// R10 - Speed on channel 0, time base channel 2
// R11 - Bypass bit suppresses direction change decoding
// R12 - Single input mode counts only A edges
// R13 - Optional inversion of quadrature A and B
// R14 - Optional inversion of index input
// R15 - Swap bit exchanges quadrature inputs
// R16 - Index from chan1 A or chan0 B
// R17 - Filter enable filters index, A and B
// R18 - Pulses shorter than length plus one dropped
// R19 - Clock on command unless off also set
// R20 - Clock off command stops counter clock
// R21 - Channel trigger clears counter, starts clock unless off also set
// R22 - Interrupt enable register sets mask bits
// R23 - Interrupt disable register clears mask bits
// R24 - Status flags sticky, cleared by status read
// R25 - Lock bit changes only with passcode
// R26 - Interrupt when enabled status flag set
//
// The AHB-Lite interface to the registers was decided locally.
module timer_block
  import tc_pkg::*;
(
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Register bus
  input wire ahb_in_s bus_in,
  output ahb_out_s bus_out,
  // Sensor and external clock pins
  input wire logic [2:0] ext_clock_pin,
  input wire logic chan0_io_line_a,
  input wire logic chan0_io_line_b,
  input wire logic chan1_io_line_a,
  input wire logic chan2_io_line_a,
  // Block outputs
  output logic [2:0] ext_clock_line,
  output logic [2:0] clock_running,
  output logic direction,
  output logic irq
);

  typedef struct packed {
    logic hready;
    logic ph;
    logic wr;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [2:0][31:0] cmr;
    logic [2:0][1:0] smmr;
    logic [2:0][15:0] ra;
    logic [2:0][15:0] rb;
    logic [2:0][15:0] rc;
    logic [2:0][15:0] cv;
    logic [2:0][7:0] chmask;
    logic [2:0] clk_on;
    logic [31:0] bmr;
    logic [1:0] fmr;
    logic lock;
    logic [2:0] qmask;
    logic [2:0] qflags;
    logic dir;
    logic [6:0] s1;
    logic [6:0] s2;
    logic [2:0] filt;
    logic [2:0] prev;
    logic [2:0][5:0] fcnt;
    logic [6:0] gap;
    logic last_b;
    logic [2:0] xc;
    logic irq;
  } state_s;

  state_s st;
  state_s next_st;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [31:0] wd;
  logic [1:0] ch;
  logic [5:0] off;
  logic in_ch;
  logic wr_en;
  logic rd_en;
  logic unlock;
  logic sync_trg;
  logic [5:0] flen;
  logic [2:0] raw_q;
  logic dec_on;
  logic ea;
  logic eb;
  logic cnt_edge;
  logic fwd;
  logic go_up;
  logic ev_idx;
  logic ev_flip;
  logic ev_fault;
  logic tb;
  logic [2:0] trig;
  logic [2:0] on_cmd;
  logic [2:0] off_cmd;
  logic [2:0] up;
  logic [2:0] down;
  logic [2:0] clr;
  logic [2:0] x_src;
  logic [1:0] sel;
  logic [31:0] rd_val;

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  assign wd = bus_in.hwdata;

  always_comb begin
    next_st = st;
    ch = st.addr[7:6];
    off = st.addr[5:0];
    in_ch = st.addr < CH_AREA_END; // R1
    wr_en = st.ph & st.wr;
    rd_en = st.ph & ~st.wr;
    unlock = ~st.lock;
    flen = st.bmr[BM_FLEN +: FLEN_W];
    // Pin synchronisers
    next_st.s1 = {chan2_io_line_a, chan1_io_line_a, chan0_io_line_b,
                  chan0_io_line_a, ext_clock_pin};
    next_st.s2 = st.s1;
    // Input conditioning
    raw_q[0] = st.s2[P_A0] ^ st.bmr[BM_INVERT_QUAD_A]; // R13
    raw_q[1] = st.s2[P_B0] ^ st.bmr[BM_INVERT_QUAD_B]; // R13
    raw_q[2] = (st.bmr[BM_IDXB] ? st.s2[P_B0] : st.s2[P_A1]) // R16
               ^ st.bmr[BM_INVERT_INDEX]; // R14
    if (st.bmr[BM_SWAP]) begin
      raw_q[1:0] = {raw_q[0], raw_q[1]}; // R15
    end
    // Input filters
    for (int i = 0; i < 3; i++) begin
      if (!st.bmr[BM_FILTER]) begin
        next_st.filt[i] = raw_q[i]; // R17
        next_st.fcnt[i] = 6'h00;
      end else if (raw_q[i] == st.filt[i]) begin
        next_st.fcnt[i] = 6'h00;
      end else if (st.fcnt[i] >= flen) begin
        next_st.filt[i] = raw_q[i]; // R18
        next_st.fcnt[i] = 6'h00;
      end else begin
        next_st.fcnt[i] = st.fcnt[i] + 6'h01; // R18
      end
    end
    next_st.prev = st.filt;
    // Edge, direction and fault detection
    dec_on = st.bmr[BM_DEC_ON];
    ea = dec_on & (st.filt[0] != st.prev[0]);
    eb = dec_on & (st.filt[1] != st.prev[1]);
    ev_idx = dec_on & st.filt[2] & ~st.prev[2];
    cnt_edge = ea | (eb & ~st.bmr[BM_SINGLE]); // R12
    fwd = ea ? (st.filt[0] != st.filt[1]) : (st.filt[0] == st.filt[1]);
    ev_flip = (ea | eb) & ~st.bmr[BM_BYPASS] & (fwd != st.dir); // R11
    go_up = st.bmr[BM_BYPASS] | fwd;
    if ((ea | eb) & ~st.bmr[BM_BYPASS]) begin
      next_st.dir = fwd; // R11
    end
    ev_fault = (ea & eb) | (((ea & st.last_b) | (eb & ~st.last_b))
               & (st.gap < {1'b0, flen}));
    if (ea | eb) begin
      next_st.gap = 7'h00;
      next_st.last_b = eb & ~ea;
    end else if (st.gap != GAP_MAX) begin
      next_st.gap = st.gap + 7'h01;
    end
    // Channel commands
    sync_trg = wr_en & (st.addr == BLK_CMD) & wd[BLK_SYNC]; // R3
    for (int i = 0; i < NUM_CH; i++) begin
      trig[i] = sync_trg | (wr_en & in_ch & (ch == 2'(i)) & (off == CH_CMD)
                & wd[CMD_TRIG]);
      on_cmd[i] = wr_en & in_ch & (ch == 2'(i)) & (off == CH_CMD)
                  & wd[CMD_CLK_ON];
      off_cmd[i] = wr_en & in_ch & (ch == 2'(i)) & (off == CH_CMD)
                   & wd[CMD_CLK_OFF];
    end
    // Counting sources
    tb = dec_on & st.bmr[BM_SPEED] & st.clk_on[2] & (st.cv[2] == st.rc[2]);
    up = 3'h7;
    down = 3'h0;
    clr = 3'h0;
    if (dec_on & st.bmr[BM_POS]) begin
      up[0] = cnt_edge & go_up; // R9
      down[0] = cnt_edge & ~go_up; // R9
      clr[0] = ev_idx; // R9
      up[1] = ev_idx & go_up; // R9
      down[1] = ev_idx & ~go_up; // R9
    end
    if (dec_on & st.bmr[BM_SPEED]) begin
      up[0] = cnt_edge & go_up; // R10
      down[0] = cnt_edge & ~go_up; // R10
      clr[0] = tb; // R10
      clr[2] = tb; // R10
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (trig[i] | (clr[i] & st.clk_on[i])) begin
        next_st.cv[i] = 16'h0000; // R21
      end else if (up[i] & st.clk_on[i]) begin
        next_st.cv[i] = st.cv[i] + 16'h0001;
      end else if (down[i] & st.clk_on[i]) begin
        next_st.cv[i] = st.cv[i] - 16'h0001;
      end
      if (off_cmd[i]) begin
        next_st.clk_on[i] = 1'b0; // R20
      end else if (on_cmd[i] | trig[i]) begin
        next_st.clk_on[i] = 1'b1; // R19 R21
      end
    end
    if (tb) begin
      next_st.ra[0] = st.cv[0]; // R10
    end
    // Channel register writes
    if (wr_en & in_ch) begin
      case (off)
        CH_MODE: if (unlock) next_st.cmr[ch] = wd;
        CH_STEP: if (unlock) next_st.smmr[ch] = wd[1:0];
        CH_RA: if (unlock & st.cmr[ch][MODE_WAVE]) begin
          next_st.ra[ch] = wd[15:0]; // R2
        end
        CH_RB: if (unlock & st.cmr[ch][MODE_WAVE]) begin
          next_st.rb[ch] = wd[15:0]; // R2
        end
        CH_RC: if (unlock) next_st.rc[ch] = wd[15:0];
        CH_IER: next_st.chmask[ch] = st.chmask[ch] | wd[7:0];
        CH_IDR: next_st.chmask[ch] = st.chmask[ch] & ~wd[7:0];
        default: ;
      endcase
    end
    // Block register writes
    if (wr_en) begin
      case (st.addr)
        BLK_MODE: if (unlock) next_st.bmr = wd & BMR_MASK; // R4
        Q_IER: next_st.qmask = st.qmask | wd[2:0]; // R22
        Q_IDR: next_st.qmask = st.qmask & ~wd[2:0]; // R23
        FAULT_CFG: if (unlock) next_st.fmr = wd[1:0];
        LOCK_CFG: begin
          if (wd[LOCK_KEY_LSB +: 24] == LOCK_KEY) begin
            next_st.lock = wd[0]; // R25
          end
        end
        default: ;
      endcase
    end
    // Sticky flags, cleared by status read, new events win
    if (rd_en & (st.addr == Q_ISR)) begin
      next_st.qflags = 3'h0; // R24
    end
    next_st.qflags = next_st.qflags | {ev_fault, ev_flip, ev_idx}; // R24
    next_st.irq = |(st.qflags & st.qmask); // R26
    // External clock line selection
    x_src = {st.s2[P_A1], st.s2[P_A0], st.s2[P_A1]};
    for (int i = 0; i < 3; i++) begin
      sel = st.bmr[2 * i +: 2];
      case (sel)
        SEL_PIN: next_st.xc[i] = st.s2[P_CLK0 + i]; // R5 R6 R7
        SEL_X: next_st.xc[i] = x_src[i]; // R5 R6 R7
        SEL_Y: next_st.xc[i] = st.s2[P_A2]; // R5 R6 R7
        default: next_st.xc[i] = 1'b0;
      endcase
    end
    // Read data
    rd_val = 32'h0000_0000;
    if (in_ch) begin
      case (off)
        CH_MODE: rd_val = st.cmr[ch];
        CH_STEP: rd_val = {30'h0000_0000, st.smmr[ch]};
        CH_CV: rd_val = {16'h0000, st.cv[ch]};
        CH_RA: rd_val = {16'h0000, st.ra[ch]};
        CH_RB: rd_val = {16'h0000, st.rb[ch]};
        CH_RC: rd_val = {16'h0000, st.rc[ch]};
        CH_SR: rd_val[SR_CLK_STA] = st.clk_on[ch];
        CH_IMR: rd_val = {24'h00_0000, st.chmask[ch]};
        default: ;
      endcase
    end else begin
      case (st.addr)
        BLK_MODE: rd_val = st.bmr;
        Q_IMR: rd_val = {29'h0000_0000, st.qmask};
        Q_ISR: begin
          rd_val[2:0] = st.qflags; // R24
          rd_val[QS_DIR] = st.dir; // R24
        end
        FAULT_CFG: rd_val = {30'h0000_0000, st.fmr};
        LOCK_CFG: rd_val = {31'h0000_0000, st.lock};
        default: ;
      endcase
    end
    // Bus handshake, one wait state per transfer
    if (st.ph) begin
      next_st.ph = 1'b0;
      next_st.hready = 1'b1;
      if (rd_en) begin
        next_st.rdata = rd_val;
      end
    end else if (bus_in.hsel & bus_in.htrans[1] & bus_in.hready) begin
      next_st.ph = 1'b1;
      next_st.hready = 1'b0;
      next_st.wr = bus_in.hwrite;
      next_st.addr = bus_in.haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.hready <= 1'b1;
      st.gap <= GAP_MAX;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign bus_out.hrdata = st.rdata;
  assign bus_out.hreadyout = st.hready;
  assign bus_out.hresp = 1'b0;
  assign ext_clock_line = st.xc;
  assign clock_running = st.clk_on;
  assign direction = st.dir;
  assign irq = st.irq;

  // Checks
  ra_readonly_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
    ce && wr_en && in_ch && ch == 2'h1 && off == CH_RA
    && !st.cmr[1][MODE_WAVE] |=> $stable(st.ra[1]))
    else $error("capture register written in capture mode");

  sync_all_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    ce && sync_trg |=> st.cv == '0 && st.clk_on == 3'h7)
    else $error("block sync did not trigger all channels");

  mode_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
    ce && wr_en && st.addr == BLK_MODE && st.lock |=> $stable(st.bmr))
    else $error("block mode changed while locked");

  line0_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
    ce && st.bmr[BM_L0 +: 2] == SEL_PIN
    |=> st.xc[0] == $past(st.s2[P_CLK0]))
    else $error("line 0 does not follow its pin");

  line1_chan0_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
    ce && st.bmr[BM_L1 +: 2] == SEL_X |=> st.xc[1] == $past(st.s2[P_A0]))
    else $error("line 1 does not follow channel 0 line A");

  filter_hold_a: assert property ( // R18
    @(posedge sys_clk) disable iff (!rst_n)
    ce && st.bmr[BM_FILTER] && st.fcnt[0] < flen |=> $stable(st.filt[0]))
    else $error("filter passed a short pulse");

  clock_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R19
    ce && on_cmd[0] && !off_cmd[0] |=> st.clk_on[0])
    else $error("clock on command ignored");

  clock_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R20
    ce && off_cmd[0] |=> !st.clk_on[0] ##1 1)
    else $error("clock off command ignored");

  mask_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R22
    ce && wr_en && st.addr == Q_IER
    |=> (st.qmask & $past(wd[2:0])) == $past(wd[2:0]))
    else $error("interrupt enable did not set mask");

  status_clear_a: assert property ( // R24
    @(posedge sys_clk) disable iff (!rst_n)
    ce && rd_en && st.addr == Q_ISR && !(ev_idx || ev_flip || ev_fault)
    |=> st.qflags == 3'h0 && st.rdata[2:0] == $past(st.qflags))
    else $error("status read did not return and clear flags");

  irq_raise_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R26
    ce && |(st.qflags & st.qmask) |=> st.irq)
    else $error("interrupt not raised for enabled flag");

  sync_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ce && sync_trg);
  index_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ce && ev_idx);
  fault_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ce && ev_fault);
  flip_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ce && ev_flip);

endmodule

// file: verification/quad_sensor.sv
// Rotary sensor model driving the quadrature and index lines
module quad_sensor (
  // Clock
  input wire logic clk,
  // Sensor lines
  output logic quad_input_a,
  output logic quad_input_b,
  output logic idx
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    quad_input_a = 1'b0;
    quad_input_b = 1'b0;
    idx = 1'b0;
  end

  // Gray steps; forward has A leading B, gap sets the speed
  task automatic steps(input int n, input bit fwd, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge clk);
      if (fwd ^ (quad_input_a ^ quad_input_b)) quad_input_a <= !quad_input_a;
      else quad_input_b <= !quad_input_b;
    end
  endtask

  // Index pulse of w cycles
  task automatic pulse(input int w);
    @(posedge clk);
    idx <= 1'b1;
    repeat (w) @(posedge clk);
    idx <= 1'b0;
  endtask

  // Static levels on A and index
  task automatic set_lv(input logic a, input logic i);
    @(posedge clk);
    quad_input_a <= a;
    idx <= i;
  endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the timer block register layer
module tb_top
  import tc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] pin = 3'h0;
  logic c2a = 1'b0;
  ahb_in_s bus_in;
  ahb_out_s bus_out;
  logic [2:0] xline;
  logic [2:0] running;
  logic dir;
  logic irq;
  logic quad_input_a;
  logic quad_input_b;
  logic idx;
  logic [31:0] rd;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  assign bus_in = {hsel, htrans, hwrite, 3'h2, haddr, hwdata,
                   bus_out.hreadyout};
  always #2.5 sys_clk = ~sys_clk;

  timer_block u_dut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .ce(1'b1),
    .bus_in(bus_in),
    .bus_out(bus_out),
    .ext_clock_pin(pin),
    .chan0_io_line_a(quad_input_a),
    .chan0_io_line_b(quad_input_b),
    .chan1_io_line_a(idx),
    .chan2_io_line_a(c2a),
    .ext_clock_line(xline),
    .clock_running(running),
    .direction(dir),
    .irq(irq)
  );

  quad_sensor u_sensor (
    .clk(sys_clk),
    .quad_input_a(quad_input_a),
    .quad_input_b(quad_input_b),
    .idx(idx)
  );

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (bus_out.hreadyout !== 1'b1 && k < 50);
    if (k >= 50) num_errors++;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (bus_out.hreadyout !== 1'b1 && k < 50);
    if (k >= 50) num_errors++;
    rd = bus_out.hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  function automatic logic [7:0] off(input int ch, input logic [5:0] r);
    return 8'(ch) * CH_STRIDE + {2'h0, r};
  endfunction

  task automatic t_map;
    rdc("block mode", BLK_MODE, 32'h0);
    rdc("irq mask", Q_IMR, 32'h0);
    rdc("status", Q_ISR, 32'h0);
    rdc("lock", LOCK_CFG, 32'h0);
    rdc("mode", off(0, CH_MODE), 32'h0);
    for (int c = 0; c < NUM_CH; c++) wr(off(c, CH_RC), 32'h100 + c);
    for (int c = 0; c < NUM_CH; c++) rdc("rc", off(c, CH_RC), 32'h100 + c);
    rdc("hole", 8'h0C, 32'h0);
    rdc("top", 8'hFC, 32'h0);
    $display("map done");
  endtask

  task automatic t_capture;
    wr(off(1, CH_RA), 32'h1234);
    rdc("ra capture", off(1, CH_RA), 32'h0);
    wr(off(1, CH_MODE), 32'h8000);
    wr(off(1, CH_RA), 32'hABCD);
    wr(off(1, CH_RB), 32'h5A5A);
    rdc("ra wave", off(1, CH_RA), 32'hABCD);
    rdc("rb wave", off(1, CH_RB), 32'h5A5A);
    wr(off(1, CH_MODE), 32'h0);
    wr(off(1, CH_RB), 32'h1111);
    rdc("rb capture", off(1, CH_RB), 32'h5A5A);
    $display("capture done");
  endtask

  task automatic t_clock;
    for (int c = 0; c < NUM_CH; c++) begin
      wr(off(c, CH_CMD), 32'h3);
      idle(3);
      chk("on and off", 0, running[c]);
      wr(off(c, CH_CMD), 32'h1);
      idle(3);
      chk("on", 1, running[c]);
      wr(off(c, CH_CMD), 32'h0);
      idle(3);
      chk("zero", 1, running[c]);
      wr(off(c, CH_CMD), 32'h2);
      idle(3);
      chk("off", 0, running[c]);
      wr(off(c, CH_CMD), 32'h4);
      idle(3);
      chk("trigger", 1, running[c]);
    end
    idle(60);
    bus(1'b0, off(0, CH_CV), 32'h0);
    chk("cv runs", 1, rd > 20);
    wr(off(0, CH_CMD), 32'h4);
    bus(1'b0, off(0, CH_CV), 32'h0);
    chk("cv cleared", 1, rd < 12);
    for (int c = 0; c < NUM_CH; c++) wr(off(c, CH_CMD), 32'h2);
    wr(BLK_CMD, 32'h0);
    idle(3);
    chk("sync zero", 0, running);
    wr(BLK_CMD, 32'h1);
    idle(3);
    chk("sync", 32'h7, running);
    $display("clock done");
  endtask

  task automatic t_lock;
    wr(LOCK_CFG, 32'h1);
    bus(1'b0, LOCK_CFG, 32'h0);
    chk("no key", 0, rd[0]);
    wr(LOCK_CFG, {LOCK_KEY, 8'h01});
    bus(1'b0, LOCK_CFG, 32'h0);
    chk("key", 1, rd[0]);
    wr(BLK_MODE, 32'h300);
    rdc("locked", BLK_MODE, 32'h0);
    wr(LOCK_CFG, {LOCK_KEY, 8'h00});
    bus(1'b0, LOCK_CFG, 32'h0);
    chk("unlock", 0, rd[0]);
    wr(BLK_MODE, 32'hFFFF_FFFF);
    rdc("mode mask", BLK_MODE, BMR_MASK);
    wr(BLK_MODE, 32'h0);
    $display("lock done");
  endtask

  task automatic t_lines;
    logic [1:0] s;
    logic [2:0] e;
    for (int i = 0; i < 3; i++) begin
      s = (i == 0) ? SEL_PIN : (i == 1) ? SEL_X : SEL_Y;
      wr(BLK_MODE, {26'h0, s, s, s});
      for (int p = 0; p < 2; p++) begin
        pin <= p[0] ? 3'h5 : 3'h2;
        c2a <= p[0];
        u_sensor.set_lv(!p[0], p[0]);
        idle(8);
        e[0] = (s == SEL_PIN) ? pin[0] : (s == SEL_X) ? idx : c2a;
        e[1] = (s == SEL_PIN) ? pin[1] : (s == SEL_X) ? quad_input_a : c2a;
        e[2] = (s == SEL_PIN) ? pin[2] : (s == SEL_X) ? idx : c2a;
        chk("clock lines", e, xline);
      end
    end
    u_sensor.set_lv(1'b0, 1'b0);
    $display("lines done");
  endtask

  task automatic t_dir;
    logic [31:0] cf [7] = '{32'h300, 32'h300, 32'h2300, 32'h4300,
                            32'h6300, 32'h10300, 32'hB00};
    bit fw [7] = '{1, 0, 0, 0, 0, 0, 1};
    bit ex [7] = '{1, 0, 1, 1, 0, 1, 0};
    for (int i = 0; i < 7; i++) begin
      wr(BLK_MODE, cf[i]);
      u_sensor.steps(8, fw[i], 4);
      idle(10);
      bus(1'b0, Q_ISR, 32'h0);
      if (i < 6) chk("direction", ex[i], dir);
      if (i < 6) chk("dir bit", ex[i], rd[QS_DIR]);
      if (i == 1) chk("flip", 1, rd[QS_FLIP]);
      if (i == 6) chk("no flip", 0, rd[QS_FLIP]);
    end
    // Single input mode counts A edges only, full mode counts both
    wr(BLK_MODE, 32'h1300);
    wr(off(0, CH_CMD), 32'h4);
    u_sensor.steps(8, 1'b1, 4);
    idle(10);
    rdc("a edges only", off(0, CH_CV), 32'h4);
    wr(BLK_MODE, 32'h300);
    wr(off(0, CH_CMD), 32'h4);
    u_sensor.steps(8, 1'b1, 4);
    idle(10);
    rdc("both edges", off(0, CH_CV), 32'h8);
    $display("direction done");
  endtask

  task automatic t_index;
    wr(BLK_MODE, 32'h48_0300);
    bus(1'b0, Q_ISR, 32'h0);
    wr(Q_IER, 32'h1);
    rdc("mask on", Q_IMR, 32'h1);
    u_sensor.pulse(3);
    idle(20);
    chk("short pulse", 0, irq);
    u_sensor.pulse(9);
    idle(20);
    chk("irq", 1, irq);
    bus(1'b0, Q_ISR, 32'h0);
    chk("index flag", 1, rd[QS_IDX]);
    idle(3);
    chk("irq cleared", 0, irq);
    bus(1'b0, Q_ISR, 32'h0);
    chk("flag cleared", 0, rd[QS_IDX]);
    wr(BLK_MODE, 32'h4A_0300);
    idle(20);
    bus(1'b0, Q_ISR, 32'h0);
    u_sensor.pulse(9);
    idle(20);
    bus(1'b0, Q_ISR, 32'h0);
    chk("other source", 0, rd[QS_IDX]);
    wr(BLK_MODE, 32'h48_0300);
    wr(Q_IDR, 32'h1);
    rdc("mask off", Q_IMR, 32'h0);
    u_sensor.pulse(9);
    idle(20);
    chk("masked", 0, irq);
    $display("index done");
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    idle(4);
    t_map();
    t_capture();
    t_clock();
    t_lock();
    t_lines();
    t_dir();
    t_index();
    wrap_up();
  end
endmodule
